// file: design/cks_regs.svh
// register offsets, field positions, keys and timing counts of the clock switch block
`ifndef CKS_REGS_SVH
`define CKS_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define CKS_OFF_CTRL 8'h00
`define CKS_OFF_KEY 8'h04
`define CKS_OFF_CTRL_HI 8'h08
`define CKS_OFF_CTRL_LO 8'h0C

// ****************************************
// unlock keys and field positions
// ****************************************
`define CKS_KEY1 16'hA55A
`define CKS_KEY2 16'h5AA5
`define CKS_NEXT_SOURCE_SEL_LSB 8
`define CKS_CF_BIT 3
`define CKS_SECONDARY_OSC_ON_BIT 1
`define CKS_SWITCH_REQUEST_BIT 0

// ****************************************
// source codes and primary submodes
// ****************************************
`define CKS_SRC_FRC 3'h0
`define CKS_SRC_FAST_RC_MULTIPLIED 3'h1
`define CKS_SRC_PRI 3'h2
`define CKS_SRC_PRIPLL 3'h3
`define CKS_SRC_SOSC 3'h4
`define CKS_SRC_LOW_POWER_RC_OSC 3'h5
`define CKS_SUB_EC 2'h0

// ****************************************
// timing
// ****************************************
`define CKS_CLK_PERIOD_NS 10
`define CKS_SWITCH_CYCLES 10
`define CKS_ATTACH_EDGES 2
`define CKS_RESUME_CYCLES 3
`define CKS_FAIL_WINDOW_NS 40000
`define CKS_FAIL_CYCLES ((`CKS_FAIL_WINDOW_NS) / (`CKS_CLK_PERIOD_NS))

`endif

// file: design/cks_pkg.sv
// types shared by the clock switch block
package cks_pkg;

	// ****************************************
	// source code and oscillator set
	// ****************************************
	typedef logic [2:0] cks_src_t;

	typedef struct packed {
		logic pll;
		logic low_power_rc_osc;
		logic sosc;
		logic pri;
		logic fast_rc_osc;
	} cks_osc_t;

	// ****************************************
	// state machines
	// ****************************************
	typedef enum logic [2:0] {SW_IDLE, SW_WAIT_RDY, SW_COUNT, SW_RELEASE, SW_ATTACH} cks_sw_t;
	typedef enum logic [2:0] {PM_RUN, PM_ENTER, PM_SLEEP, PM_IDLE, PM_WAKE} cks_pm_t;

endpackage : cks_pkg

// file: design/cks_sync.sv
// two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/100ps

module cks_sync #(
	parameter int W = 1
) (
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset
	input wire logic [W-1:0] d, // asynchronous inputs
	output logic [W-1:0] q // synchronised outputs
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// ****************************************
	// two stages, first read only by second
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end

	assign q = sync_q;

endmodule : cks_sync

// file: design/cks_clock_switch.sv
// clock source switch, fail-safe watcher and sleep/idle control
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/100ps
`include "cks_regs.svh"

module cks_clock_switch (
	input wire logic CLK, // system clock, 100 MHz
	input wire logic RST, // synchronous reset, active high
	input wire logic [7:0] ADDR, // register byte address
	input wire logic [15:0] WDATA, // register write data
	input wire logic WR, // write strobe
	input wire logic RD, // read strobe
	output logic [15:0] RDATA, // read data, cycle after read strobe
	input wire logic CFG_SWITCH_MON, // switch_monitor_cfg_bit, low enables
	input wire logic [2:0] CFG_INIT_SRC, // initial_source_cfg
	input wire logic [1:0] CFG_PRI_SUBMODE, // primary_submode_cfg
	input wire logic WDT_ENABLE, // watchdog_counter enabled
	input wire logic WDT_TIMEOUT, // watchdog_counter time-out pulse
	input wire logic [4:0] OSC_CLK_IN, // raw clocks: pll, low_power_rc_osc, sosc, pri, frc
	input wire logic OST_DONE, // osc_startup_timer expired, async
	input wire logic PLL_LOCK, // pll lock, async
	input wire logic POWER_SAVE_INSTR_REQ, // power_save_instr executed, pulse
	input wire logic POWER_SAVE_INSTR_IDLE, // mode of the instruction, 1 idle
	input wire logic IRQ_WAKE, // enabled interrupt pending
	output logic [4:0] OSC_EN, // oscillator enables: pll, low_power_rc_osc, sosc, pri, frc
	output logic PLL_FROM_PRI, // pll reference is the primary oscillator
	output logic [1:0] PRI_SUBMODE, // fixed primary submode
	output logic [4:0] CLK_GATE, // one-hot system clock mux gates
	output logic FAIL_TRAP, // clock failure trap pulse
	output logic WDT_CLEAR, // watchdog clear pulse
	output logic CPU_RUN, // CPU clock applied
	output logic SLEEP_ACT, // in sleep
	output logic IDLE_ACT, // in idle
	output logic PERIPH_CLK_ON, // system clock reaches peripherals
	output logic RESUME // instruction execution resumes, pulse
);

	// ****************************************
	// declarations
	// ****************************************
	logic [6:0] sync_w;
	logic [4:0] clk_s;
	logic [4:0] clk_d_q;
	logic [4:0] rise;
	logic ost_s;
	logic lock_s;
	logic cfg_ld_q;
	logic swmon_q;
	logic [1:0] submode_q;
	cks_pkg::cks_src_t current_source_status_q;
	cks_pkg::cks_src_t next_source_sel_q;
	cks_pkg::cks_src_t target_q;
	logic lock_q;
	logic cf_q;
	logic secondary_osc_on_q;
	logic switch_request_q;
	logic [1:0] key_q;
	logic [15:0] rdata_q;
	cks_pkg::cks_sw_t sw_q;
	cks_pkg::cks_pm_t pm_q;
	logic [3:0] cnt_q;
	logic fail_sw_q;
	logic [4:0] gate_q;
	logic [4:0] osc_en_q;
	logic [11:0] fail_cnt_q;
	logic fail_trap_q;
	logic wdt_clr_q;
	logic mode_idle_q;
	logic pend_q;
	logic [1:0] wake_cnt_q;
	logic woke_rdy_q;
	logic resume_q;

	// ****************************************
	// source helpers
	// ****************************************
	function automatic cks_pkg::cks_osc_t src_need(input cks_pkg::cks_src_t s);
		cks_pkg::cks_osc_t n;
		n = '0;
		case (s)
			`CKS_SRC_FAST_RC_MULTIPLIED: begin
				n.fast_rc_osc = 1'b1;
				n.pll = 1'b1;
			end
			`CKS_SRC_PRI: n.pri = 1'b1;
			`CKS_SRC_PRIPLL: begin
				n.pri = 1'b1;
				n.pll = 1'b1;
			end
			`CKS_SRC_SOSC: n.sosc = 1'b1;
			`CKS_SRC_LOW_POWER_RC_OSC: n.low_power_rc_osc = 1'b1;
			default: n.fast_rc_osc = 1'b1;
		endcase
		return n;
	endfunction : src_need

	// gate the clock that really drives the system: pll output when used
	function automatic cks_pkg::cks_osc_t gate_of(input cks_pkg::cks_src_t s);
		cks_pkg::cks_osc_t n;
		n = src_need(s);
		if (n.pll) begin
			n.fast_rc_osc = 1'b0;
			n.pri = 1'b0;
		end
		return n;
	endfunction : gate_of

	// ****************************************
	// input synchronisation and edge detect
	// ****************************************
	cks_sync #(.W(7)) u_sync (
		.clk(CLK),
		.rst(RST),
		.d({PLL_LOCK, OST_DONE, OSC_CLK_IN}),
		.q(sync_w)
	);

	assign clk_s = sync_w[4:0];
	assign ost_s = sync_w[5];
	assign lock_s = sync_w[6];
	assign rise = clk_s & ~clk_d_q;

	always_ff @(posedge CLK) begin
		if (RST) clk_d_q <= '0;
		else clk_d_q <= clk_s;
	end

	// ****************************************
	// decode and status
	// ****************************************
	wire sw_en = cfg_ld_q & ~swmon_q;
	wire failsafe_clock_watcher_en = sw_en;
	wire busy = (sw_q != cks_pkg::SW_IDLE);
	wire asleep = (pm_q == cks_pkg::PM_SLEEP) | ((pm_q == cks_pkg::PM_WAKE) & ~mode_idle_q);
	wire [4:0] tgt_gate = gate_of(target_q);
	wire cks_pkg::cks_osc_t tgt_need = src_need(target_q);
	wire tgt_pri = (target_q == `CKS_SRC_PRI) | (target_q == `CKS_SRC_PRIPLL);
	wire tgt_xtal = (tgt_pri & (submode_q != `CKS_SUB_EC)) | (target_q == `CKS_SRC_SOSC);
	wire tgt_ready = (~tgt_need.pll | lock_q) & (~tgt_xtal | ost_s);
	wire new_edge = |(rise & tgt_gate);
	wire old_low = ~|(clk_s & gate_q);
	wire cur_edge = |(rise & gate_q);
	wire cks_pkg::cks_osc_t cur_need = src_need(current_source_status_q);
	wire [2:0] fallback = cur_need.pll ? `CKS_SRC_FAST_RC_MULTIPLIED : `CKS_SRC_FRC;
	wire mon_en = failsafe_clock_watcher_en & ~busy & ~asleep & (pm_q != cks_pkg::PM_ENTER);
	wire fail_det = mon_en & (fail_cnt_q == 12'(`CKS_FAIL_CYCLES - 1));
	wire sw_go = sw_en & switch_request_q & ~busy & (pm_q == cks_pkg::PM_RUN) & ~fail_det;
	wire sw_same = sw_go & (next_source_sel_q == current_source_status_q);
	wire sw_start = sw_go & ~sw_same;
	wire sw_done = (sw_q == cks_pkg::SW_ATTACH) & new_edge
		& (cnt_q == 4'(`CKS_ATTACH_EDGES - 1));
	wire wake_ev = IRQ_WAKE | WDT_TIMEOUT | pend_q;

	// ****************************************
	// register bus decode
	// ****************************************
	wire wr_key = WR & (ADDR == `CKS_OFF_KEY);
	wire unlocked = (key_q == 2'h2);
	wire wr_hi = WR & (ADDR == `CKS_OFF_CTRL_HI) & unlocked;
	wire wr_lo = WR & (ADDR == `CKS_OFF_CTRL_LO) & unlocked;
	wire rd_hit = (ADDR == `CKS_OFF_CTRL) | (ADDR == `CKS_OFF_CTRL_HI) | (ADDR == `CKS_OFF_CTRL_LO);
	wire [15:0] ctrl_word = {1'b0, current_source_status_q, 1'b0, next_source_sel_q, 2'b00, lock_q, 1'b0, cf_q, 1'b0, secondary_osc_on_q,
		switch_request_q};
	wire osw_set = wr_lo & WDATA[`CKS_SWITCH_REQUEST_BIT] & sw_en;

	// unlock: two keys in a row, any other write cancels
	always_ff @(posedge CLK) begin
		if (RST) key_q <= 2'h0;
		else if (wr_key & (key_q == 2'h0) & (WDATA == `CKS_KEY1)) key_q <= 2'h1;
		else if (wr_key & (key_q == 2'h1) & (WDATA == `CKS_KEY2)) key_q <= 2'h2;
		else if (WR) key_q <= 2'h0;
	end

	// read data stands one cycle after the strobe
	always_ff @(posedge CLK) begin
		if (RST) rdata_q <= 16'h0000;
		else rdata_q <= (RD & rd_hit) ? ctrl_word : 16'h0000;
	end

	// ****************************************
	// configuration capture after reset release
	// ****************************************
	always_ff @(posedge CLK) begin
		if (RST) begin
			cfg_ld_q <= 1'b0;
			swmon_q <= 1'b1;
			submode_q <= `CKS_SUB_EC;
		end else if (!cfg_ld_q) begin
			cfg_ld_q <= 1'b1;
			swmon_q <= CFG_SWITCH_MON;
			submode_q <= CFG_PRI_SUBMODE;
		end
	end

	// ****************************************
	// source selection fields
	// ****************************************
	always_ff @(posedge CLK) begin
		if (RST) begin
			current_source_status_q <= `CKS_SRC_FRC;
			next_source_sel_q <= `CKS_SRC_FRC;
		end else if (!cfg_ld_q) begin
			current_source_status_q <= CFG_INIT_SRC;
			next_source_sel_q <= CFG_INIT_SRC;
		end else if (sw_done) begin
			current_source_status_q <= target_q;
			if (fail_sw_q) next_source_sel_q <= target_q;
		end else if (wr_hi) begin
			next_source_sel_q <= WDATA[`CKS_NEXT_SOURCE_SEL_LSB +: 3];
		end
	end

	// request bit: set by software, cleared by hardware, set wins
	always_ff @(posedge CLK) begin
		if (RST) switch_request_q <= 1'b0;
		else if (!sw_en) switch_request_q <= 1'b0;
		else if (osw_set) switch_request_q <= 1'b1;
		else if (sw_same | (sw_done & ~fail_sw_q)) switch_request_q <= 1'b0;
	end

	// lock and fail flags, secondary oscillator enable
	always_ff @(posedge CLK) begin
		if (RST) begin
			lock_q <= 1'b0;
			cf_q <= 1'b0;
			secondary_osc_on_q <= 1'b0;
		end else begin
			if (sw_start) lock_q <= 1'b0;
			else lock_q <= lock_s & osc_en_q[4];
			if (fail_det) cf_q <= 1'b1;
			else if (sw_start) cf_q <= 1'b0;
			else if (wr_lo & ~WDATA[`CKS_CF_BIT]) cf_q <= 1'b0;
			if (wr_lo) secondary_osc_on_q <= WDATA[`CKS_SECONDARY_OSC_ON_BIT];
		end
	end

	// ****************************************
	// switch sequencer
	// ****************************************
	always_ff @(posedge CLK) begin
		if (RST) begin
			sw_q <= cks_pkg::SW_IDLE;
			target_q <= `CKS_SRC_FRC;
			cnt_q <= 4'h0;
			fail_sw_q <= 1'b0;
		end else if (!asleep) begin
			case (sw_q)
				cks_pkg::SW_IDLE: begin
					cnt_q <= 4'h0;
					if (fail_det) begin
						target_q <= fallback;
						fail_sw_q <= 1'b1;
						sw_q <= cks_pkg::SW_WAIT_RDY;
					end else if (sw_start) begin
						target_q <= next_source_sel_q;
						fail_sw_q <= 1'b0;
						sw_q <= cks_pkg::SW_WAIT_RDY;
					end
				end
				cks_pkg::SW_WAIT_RDY: begin
					if (tgt_ready) sw_q <= cks_pkg::SW_COUNT;
				end
				cks_pkg::SW_COUNT: begin
					if (new_edge) begin
						cnt_q <= cnt_q + 4'h1;
						if (cnt_q == 4'(`CKS_SWITCH_CYCLES - 1)) begin
							cnt_q <= 4'h0;
							sw_q <= cks_pkg::SW_RELEASE;
						end
					end
				end
				cks_pkg::SW_RELEASE: begin
					if (old_low) sw_q <= cks_pkg::SW_ATTACH;
				end
				cks_pkg::SW_ATTACH: begin
					if (new_edge) cnt_q <= cnt_q + 4'h1;
					if (sw_done) sw_q <= cks_pkg::SW_IDLE;
				end
				default: sw_q <= cks_pkg::SW_IDLE;
			endcase
		end
	end

	// mux gates: break on the old low phase, make after new edges
	always_ff @(posedge CLK) begin
		if (RST) gate_q <= 5'h00;
		else if (!cfg_ld_q) gate_q <= gate_of(CFG_INIT_SRC);
		else if ((sw_q == cks_pkg::SW_RELEASE) & old_low) gate_q <= 5'h00;
		else if (sw_done) gate_q <= tgt_gate;
	end

	// ****************************************
	// oscillator enables
	// ****************************************
	always_ff @(posedge CLK) begin
		if (RST) begin
			osc_en_q <= 5'h00;
		end else begin
			// sources restart in the wake state so the sleep clock can come back
			osc_en_q <= (cur_need | (busy ? tgt_need : 5'h00)) & {5{(pm_q != cks_pkg::PM_SLEEP) & cfg_ld_q}};
			if (secondary_osc_on_q) osc_en_q[2] <= 1'b1;
			if (WDT_ENABLE | (failsafe_clock_watcher_en & ~asleep)) osc_en_q[3] <= 1'b1;
		end
	end

	// ****************************************
	// fail-safe watcher
	// ****************************************
	always_ff @(posedge CLK) begin
		if (RST) begin
			fail_cnt_q <= 12'h000;
			fail_trap_q <= 1'b0;
		end else begin
			fail_trap_q <= fail_det;
			if (!mon_en | cur_edge | fail_det) fail_cnt_q <= 12'h000;
			else fail_cnt_q <= fail_cnt_q + 12'h001;
		end
	end

	// ****************************************
	// sleep and idle control
	// ****************************************
	always_ff @(posedge CLK) begin
		if (RST) begin
			pm_q <= cks_pkg::PM_RUN;
			mode_idle_q <= 1'b0;
			pend_q <= 1'b0;
			wake_cnt_q <= 2'h0;
			woke_rdy_q <= 1'b0;
		end else if (cfg_ld_q) begin
			case (pm_q)
				cks_pkg::PM_RUN: begin
					pend_q <= 1'b0;
					if (POWER_SAVE_INSTR_REQ) begin
						mode_idle_q <= POWER_SAVE_INSTR_IDLE;
						pm_q <= cks_pkg::PM_ENTER;
					end
				end
				cks_pkg::PM_ENTER: begin
					pend_q <= pend_q | IRQ_WAKE;
					pm_q <= mode_idle_q ? cks_pkg::PM_IDLE : cks_pkg::PM_SLEEP;
				end
				cks_pkg::PM_SLEEP, cks_pkg::PM_IDLE: begin
					wake_cnt_q <= 2'h0;
					woke_rdy_q <= mode_idle_q;
					if (wake_ev) pm_q <= cks_pkg::PM_WAKE;
				end
				cks_pkg::PM_WAKE: begin
					pend_q <= 1'b0;
					if (cur_edge) woke_rdy_q <= 1'b1;
					if (woke_rdy_q) wake_cnt_q <= wake_cnt_q + 2'h1;
					if (woke_rdy_q & (wake_cnt_q == 2'(`CKS_RESUME_CYCLES - 1))) pm_q <= cks_pkg::PM_RUN;
				end
				default: pm_q <= cks_pkg::PM_RUN;
			endcase
		end
	end

	// watchdog clear on entry, resume pulse on return to run
	always_ff @(posedge CLK) begin
		if (RST) begin
			wdt_clr_q <= 1'b0;
			resume_q <= 1'b0;
		end else begin
			wdt_clr_q <= (pm_q == cks_pkg::PM_RUN) & POWER_SAVE_INSTR_REQ & WDT_ENABLE & cfg_ld_q;
			resume_q <= (pm_q == cks_pkg::PM_WAKE) & woke_rdy_q
				& (wake_cnt_q == 2'(`CKS_RESUME_CYCLES - 1));
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign RDATA = rdata_q;
	assign OSC_EN = osc_en_q;
	assign PLL_FROM_PRI = busy ? tgt_pri : ((current_source_status_q == `CKS_SRC_PRI) | (current_source_status_q == `CKS_SRC_PRIPLL));
	assign PRI_SUBMODE = submode_q;
	assign CLK_GATE = gate_q & {5{~asleep}};
	assign FAIL_TRAP = fail_trap_q;
	assign WDT_CLEAR = wdt_clr_q;
	assign CPU_RUN = (pm_q == cks_pkg::PM_RUN) | (pm_q == cks_pkg::PM_ENTER);
	assign SLEEP_ACT = asleep;
	assign IDLE_ACT = (pm_q == cks_pkg::PM_IDLE) | ((pm_q == cks_pkg::PM_WAKE) & mode_idle_q);
	assign PERIPH_CLK_ON = ~asleep;
	assign RESUME = resume_q;

endmodule : cks_clock_switch

// file: tb/cks_monitor.sv
// port checker of the clock switch block
`timescale 1ns/100ps

module cks_monitor (
	input wire logic CLK, // system clock
	input wire logic RST, // reset
	input wire logic RD, // read strobe
	input wire logic [15:0] RDATA, // read data
	input wire logic CFG_SWITCH_MON, // switching config
	input wire logic POWER_SAVE_INSTR_REQ, // power save request
	input wire logic WDT_ENABLE, // watchdog on
	input wire logic [1:0] PRI_SUBMODE, // primary submode
	input wire logic [4:0] CLK_GATE, // mux gates
	input wire logic FAIL_TRAP, // failure trap
	input wire logic WDT_CLEAR, // watchdog clear
	input wire logic CPU_RUN, // cpu clock on
	input wire logic SLEEP_ACT, // in sleep
	input wire logic IDLE_ACT, // in idle
	input wire logic PERIPH_CLK_ON, // peripheral clock on
	input wire logic RESUME // execution resumes
);
	// ****************************
	// properties
	// ****************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	property p_onehot; $onehot0(CLK_GATE); endproperty
	a_onehot: assert property (p_onehot) else $error("gate not one-hot");
	property p_bbm; $past(CLK_GATE) != 5'h00 && CLK_GATE != 5'h00 |-> CLK_GATE == $past(CLK_GATE); endproperty
	a_bbm: assert property (p_bbm) else $error("gate moved without release");
	property p_trap; FAIL_TRAP |-> ##[1:600] $rose(CLK_GATE[0] || CLK_GATE[4]); endproperty
	a_trap: assert property (p_trap) else $error("no fallback after trap");
	property p_sleep_off; $rose(SLEEP_ACT) |-> CLK_GATE == 5'h00 && !PERIPH_CLK_ON && !CPU_RUN; endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("clock alive in sleep");
	property p_sleep_quiet; SLEEP_ACT |-> !FAIL_TRAP; endproperty
	a_sleep_quiet: assert property (p_sleep_quiet) else $error("trap in sleep");
	property p_wdt; WDT_CLEAR |-> $past(POWER_SAVE_INSTR_REQ) && $past(WDT_ENABLE); endproperty
	a_wdt: assert property (p_wdt) else $error("stray watchdog clear");
	property p_idle_clk; IDLE_ACT |-> PERIPH_CLK_ON && CLK_GATE != 5'h00; endproperty
	a_idle_clk: assert property (p_idle_clk) else $error("clock off in idle");
	property p_resume; RESUME |-> CPU_RUN && $past(SLEEP_ACT || IDLE_ACT); endproperty
	a_resume: assert property (p_resume) else $error("resume without wake");
	property p_req_zero; CFG_SWITCH_MON && $past(RD) |-> RDATA[0] == 1'b0; endproperty
	a_req_zero: assert property (p_req_zero) else $error("request bit set while locked");
	property p_submode; !$past(RST) && !$past(RST, 2) |-> $stable(PRI_SUBMODE); endproperty
	a_submode: assert property (p_submode) else $error("submode changed");
	property p_rd_zero; !$past(RD) |-> RDATA == 16'h0000; endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("read data outside read cycle");
	c_attach: cover property ($rose(CLK_GATE[1]));
	c_trap: cover property (FAIL_TRAP);
	c_resume: cover property (RESUME && $past(IDLE_ACT));
endmodule : cks_monitor

bind cks_clock_switch cks_monitor mon_u (.CLK(CLK), .RST(RST), .RD(RD), .RDATA(RDATA),
	.CFG_SWITCH_MON(CFG_SWITCH_MON), .POWER_SAVE_INSTR_REQ(POWER_SAVE_INSTR_REQ), .WDT_ENABLE(WDT_ENABLE),
	.PRI_SUBMODE(PRI_SUBMODE), .CLK_GATE(CLK_GATE), .FAIL_TRAP(FAIL_TRAP), .WDT_CLEAR(WDT_CLEAR),
	.CPU_RUN(CPU_RUN), .SLEEP_ACT(SLEEP_ACT), .IDLE_ACT(IDLE_ACT), .PERIPH_CLK_ON(PERIPH_CLK_ON),
	.RESUME(RESUME));

// file: tb/cks_osc_model.sv
// oscillator sources, start-up timer and pll lock facing the clock switch
`timescale 1ns/100ps

module cks_osc_model (
	input wire logic [4:0] osc_en, // enables pll, low_power_rc_osc, sosc, pri, fast rc
	input wire logic pll_from_pri, // pll reference select
	input wire logic pri_dead, // primary crystal has failed
	output logic [4:0] clk_out, // raw clocks
	output logic startup_done, // start-up timer expired
	output logic pll_lock // pll locked
);
	int startup_cnt = 0;
	int lock_cnt = 0;
	logic pri_ok;
	logic ref_ok;
	// ****************************
	// clocks
	// ****************************
	assign pri_ok = osc_en[1] && !pri_dead;
	assign ref_ok = osc_en[4] && (pll_from_pri ? pri_ok : osc_en[0]);
	initial clk_out = 5'h00;
	// each clock stands low while its oscillator is off
	always #7 clk_out[0] = osc_en[0] ? ~clk_out[0] : 1'b0;
	always #12 clk_out[1] = pri_ok ? ~clk_out[1] : 1'b0;
	always #50 clk_out[2] = osc_en[2] ? ~clk_out[2] : 1'b0;
	always #100 clk_out[3] = osc_en[3] ? ~clk_out[3] : 1'b0;
	always #3 clk_out[4] = (ref_ok && pll_lock) ? ~clk_out[4] : 1'b0;
	// start-up and lock delays, 10 ns a step, lost with the source
	always #10 begin
		startup_cnt = (osc_en[1] || osc_en[2]) ? ((startup_cnt < 50) ? startup_cnt + 1 : 50) : 0;
		lock_cnt = ref_ok ? ((lock_cnt < 30) ? lock_cnt + 1 : 30) : 0;
	end
	assign startup_done = (startup_cnt == 50);
	assign pll_lock = (lock_cnt == 30);
endmodule : cks_osc_model

// file: tb/tb_top.sv
// self-checking bench of the clock switch block
`timescale 1ns/100ps
`include "cks_regs.svh"

module tb_top;
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic [7:0] ADDR = 8'h00;
	logic [15:0] WDATA = 16'h0000;
	logic WR = 1'b0, RD = 1'b0, CFG_SWITCH_MON = 1'b1, WDT_ENABLE = 1'b1, WDT_TIMEOUT = 1'b0;
	logic POWER_SAVE_INSTR_REQ = 1'b0, POWER_SAVE_INSTR_IDLE = 1'b0, IRQ_WAKE = 1'b0, pri_dead = 1'b0;
	logic [2:0] CFG_INIT_SRC = `CKS_SRC_LOW_POWER_RC_OSC;
	logic [1:0] CFG_PRI_SUBMODE = 2'h1;
	logic [15:0] RDATA;
	logic [4:0] OSC_CLK_IN, OSC_EN, CLK_GATE;
	logic [1:0] PRI_SUBMODE;
	logic OST_DONE, PLL_LOCK, PLL_FROM_PRI, FAIL_TRAP, WDT_CLEAR, CPU_RUN, SLEEP_ACT, IDLE_ACT;
	logic PERIPH_CLK_ON, RESUME;
	int error_cnt = 0, checks_done = 0, cyc = 0, t_ready = 0;
	logic [15:0] d;
	int n;
	// ****************************
	// design and oscillators
	// ****************************
	cks_clock_switch dut_u (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .CFG_SWITCH_MON(CFG_SWITCH_MON), .CFG_INIT_SRC(CFG_INIT_SRC),
		.CFG_PRI_SUBMODE(CFG_PRI_SUBMODE), .WDT_ENABLE(WDT_ENABLE), .WDT_TIMEOUT(WDT_TIMEOUT),
		.OSC_CLK_IN(OSC_CLK_IN), .OST_DONE(OST_DONE), .PLL_LOCK(PLL_LOCK), .POWER_SAVE_INSTR_REQ(POWER_SAVE_INSTR_REQ),
		.POWER_SAVE_INSTR_IDLE(POWER_SAVE_INSTR_IDLE), .IRQ_WAKE(IRQ_WAKE), .OSC_EN(OSC_EN), .PLL_FROM_PRI(PLL_FROM_PRI),
		.PRI_SUBMODE(PRI_SUBMODE), .CLK_GATE(CLK_GATE), .FAIL_TRAP(FAIL_TRAP), .WDT_CLEAR(WDT_CLEAR),
		.CPU_RUN(CPU_RUN), .SLEEP_ACT(SLEEP_ACT), .IDLE_ACT(IDLE_ACT), .PERIPH_CLK_ON(PERIPH_CLK_ON),
		.RESUME(RESUME));
	cks_osc_model osc_u (.osc_en(OSC_EN), .pll_from_pri(PLL_FROM_PRI), .pri_dead(pri_dead),
		.clk_out(OSC_CLK_IN), .startup_done(OST_DONE), .pll_lock(PLL_LOCK));
	// clock, cycle count and start-up time stamp
	always #5 CLK = ~CLK;
	always @(posedge CLK) cyc <= cyc + 1;
	always @(posedge OST_DONE) t_ready = cyc;
	// ****************************
	// bus and helper tasks
	// ****************************
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= v;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		#1 d = RDATA;
	endtask : rd
	// two keys then the protected write
	task automatic ul(input logic [7:0] a, input logic [15:0] v);
		wr(`CKS_OFF_KEY, `CKS_KEY1);
		wr(`CKS_OFF_KEY, `CKS_KEY2);
		wr(a, v);
	endtask : ul
	task automatic req(input logic [2:0] src);
		ul(`CKS_OFF_CTRL_HI, {5'h00, src, 8'h00});
		ul(`CKS_OFF_CTRL_LO, 16'h0001);
	endtask : req
	task automatic wait_gate(input logic [4:0] g);
		n = 0;
		// every real switch releases all gates before the new one attaches
		while (CLK_GATE !== 5'h00 && n < 6000) begin
			@(posedge CLK);
			#1 n++;
		end
		while (!(CLK_GATE === g && PLL_FROM_PRI === ((g == 5'h10 || g == 5'h02) && !pri_dead)) && n < 6000) begin
			@(posedge CLK);
			#1 n++;
		end
		chk("gate wait", 16'(n < 6000), 16'h0001);
	endtask : wait_gate
	task automatic wait_resume();
		n = 0;
		while (RESUME !== 1'b1 && n < 300) begin
			@(posedge CLK);
			#1 n++;
		end
		chk("resume wait", 16'(n < 300), 16'h0001);
	endtask : wait_resume
	task automatic pulse_save(input logic idle);
		@(posedge CLK);
		POWER_SAVE_INSTR_IDLE <= idle;
		POWER_SAVE_INSTR_REQ <= 1'b1;
		@(posedge CLK);
		POWER_SAVE_INSTR_REQ <= 1'b0;
	endtask : pulse_save
	task automatic reset_dut(input logic mon, input logic [2:0] src);
		@(posedge CLK);
		RST <= 1'b1;
		CFG_SWITCH_MON <= mon;
		CFG_INIT_SRC <= src;
		repeat (20) @(posedge CLK);
		RST <= 1'b0;
		repeat (3) @(posedge CLK);
	endtask : reset_dut
	// ****************************
	// scenarios
	// ****************************
	task automatic t_locked();
		reset_dut(1'b1, `CKS_SRC_LOW_POWER_RC_OSC);
		req(`CKS_SRC_PRI);
		repeat (100) @(posedge CLK);
		rd(`CKS_OFF_CTRL);
		chk("current source", 16'(d[14:12]), 16'(`CKS_SRC_LOW_POWER_RC_OSC));
		chk("switch request", 16'(d[0]), 16'h0000);
		chk("locked gate", 16'(CLK_GATE), 16'h0008);
		chk("submode", 16'(PRI_SUBMODE), 16'h0001);
		rd(8'h10);
		chk("unmapped read", d, 16'h0000);
	endtask : t_locked
	task automatic t_switch();
		reset_dut(1'b0, `CKS_SRC_FRC);
		wr(`CKS_OFF_CTRL_HI, 16'h0200);
		rd(`CKS_OFF_CTRL);
		chk("next without keys", 16'(d[10:8]), 16'(`CKS_SRC_FRC));
		req(`CKS_SRC_FRC);
		repeat (10) @(posedge CLK);
		rd(`CKS_OFF_CTRL);
		chk("redundant request", 16'(d[0]), 16'h0000);
		req(`CKS_SRC_PRI);
		wait_gate(5'h02);
		chk("primary gate", 16'(CLK_GATE), 16'h0002);
		chk("ten edges", 16'((cyc - t_ready) >= 25), 16'h0001);
		rd(`CKS_OFF_CTRL);
		chk("switched source", 16'({d[14:12], d[0]}), 16'({`CKS_SRC_PRI, 1'b0}));
		repeat (5) @(posedge CLK);
		chk("old source off", 16'(OSC_EN & 5'h09), 16'h0008);
	endtask : t_switch
	task automatic t_fail();
		req(`CKS_SRC_PRIPLL); // from plain primary, never straight from fast rc with pll
		wait_gate(5'h10);
		chk("pll from primary", 16'({CLK_GATE, PLL_FROM_PRI}), 16'h0021);
		pri_dead = 1'b1;
		n = 0;
		while (FAIL_TRAP !== 1'b1 && n < 5000) begin
			@(posedge CLK);
			#1 n++;
		end
		chk("trap", 16'(FAIL_TRAP), 16'h0001);
		wait_gate(5'h10);
		chk("fallback via pll", 16'({CLK_GATE, PLL_FROM_PRI}), 16'h0020);
		rd(`CKS_OFF_CTRL);
		chk("fallback source", 16'({d[14:12], d[3]}), 16'({`CKS_SRC_FAST_RC_MULTIPLIED, 1'b1}));
		ul(`CKS_OFF_CTRL_LO, 16'h0000);
		rd(`CKS_OFF_CTRL);
		chk("fail flag cleared", 16'(d[3]), 16'h0000);
		ul(`CKS_OFF_CTRL_LO, 16'h0008);
		rd(`CKS_OFF_CTRL);
		chk("fail flag not set", 16'(d[3]), 16'h0000);
	endtask : t_fail
	task automatic t_sleep();
		pulse_save(1'b0);
		#1 chk("watchdog clear", 16'(WDT_CLEAR), 16'h0001);
		repeat (5) @(posedge CLK);
		#1 chk("sleep state", 16'({SLEEP_ACT, PERIPH_CLK_ON, CLK_GATE}), 16'h0040);
		chk("sleep oscillators", 16'(OSC_EN & 5'h19), 16'h0008);
		@(posedge CLK);
		IRQ_WAKE <= 1'b1;
		@(posedge CLK);
		IRQ_WAKE <= 1'b0;
		wait_resume();
		chk("sleep wake", 16'({CPU_RUN, CLK_GATE}), 16'h0030);
	endtask : t_sleep
	task automatic t_idle();
		pulse_save(1'b1);
		IRQ_WAKE <= 1'b1;
		@(posedge CLK);
		IRQ_WAKE <= 1'b0;
		wait_resume();
		chk("deferred wake", 16'(n <= 8), 16'h0001);
		pulse_save(1'b1);
		repeat (5) @(posedge CLK);
		#1 chk("idle state", 16'({IDLE_ACT, CPU_RUN, PERIPH_CLK_ON, CLK_GATE}), 16'h00B0);
		chk("idle slow rc", 16'(OSC_EN[3]), 16'h0001);
		@(posedge CLK);
		WDT_TIMEOUT <= 1'b1;
		@(posedge CLK);
		WDT_TIMEOUT <= 1'b0;
		wait_resume();
		chk("resume delay", 16'(n >= 2 && n <= 5), 16'h0001);
	endtask : t_idle
	// ****************************
	// run control
	// ****************************
	task automatic test_done();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done
	// main sequence
	initial begin
		t_locked();
		t_switch();
		t_fail();
		t_sleep();
		t_idle();
		test_done();
	end
	// watchdog against a hang
	initial begin
		#300000;
		error_cnt++;
		test_done();
	end
endmodule : tb_top
